// ### saddr_agent_end.sv
// saddr_agent_end: far bus agent end, sends and receives address phases and drives straps
`timescale 1ns/1ps
module saddr_agent_end
  import saddr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  saddr_if.agt_mp bus,
  input wire logic reqValid,
  output logic reqReady,
  input wire saddr_bus_t reqAddr,
  input wire saddr_bus_t reqType,
  output logic txDone,
  output logic rxValid,
  output saddr_bus_t rxAddr,
  output saddr_bus_t rxType,
  output logic rxParErr,
  input wire logic [CFG_W-1:0] strapBits
);

  // whole state of this end
  typedef struct packed {
    saddr_link_t link; // common sender and receiver
    logic [3:0] strapCnt; // cycles of strap drive left after reset
  } saddr_agt_st_t;

  saddr_agt_st_t st_ff; // registered state
  saddr_agt_st_t nxt_st; // next state
  logic strapOn; // straps are being held on the lines
  logic tick; // divider pulse, end of a half period
  logic [1:0] stbNow; // synchronised strobe levels
  logic [1:0] stbStable; // second and third stage agree
  saddr_bus_t lineAct; // synchronised lines, active high
  logic [1:0] parAct; // synchronised parity, active high
  saddr_bus_t strapLines; // electrical strap pattern

  assign strapOn = (st_ff.strapCnt != 4'h0);
  assign tick = (st_ff.link.cnt == 8'h00);
  assign stbNow = st_ff.link.sync[2][ADDR_W +: STB_W];
  assign stbStable = ~(st_ff.link.sync[1][ADDR_W +: STB_W] ^ stbNow);
  assign lineAct = ~st_ff.link.sync[2][ADDR_W-1:0]; // [R7]
  assign parAct = ~st_ff.link.sync[2][ADDR_W+STB_W +: PAR_W]; // [R7]

  // strap pattern: only the config lines are pulled low where a bit is one
  always_comb begin
    strapLines = '1;
    strapLines[CFG_LO +: CFG_W] = ~strapBits; // [R6]
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.link.txDone = 1'b0;
    nxt_st.link.rxValid = 1'b0;
    // strap hold runs down after reset release
    if (strapOn) begin
      nxt_st.strapCnt = 4'(st_ff.strapCnt - 4'h1); // [R6]
    end
    // divider runs only while a phase is on the wires
    if (st_ff.link.tx != TX_IDLE) begin
      nxt_st.link.cnt = tick ? HALF_M1 : 8'(st_ff.link.cnt - 8'h01);
    end
    unique case (st_ff.link.tx)
      TX_IDLE: begin
        // take a request only on a quiet bus
        if (reqValid && reqReady) begin
          nxt_st.link.txType = reqType;
          nxt_st.link.lineOut = ~reqAddr; // [R2] [R7]
          nxt_st.link.parOut = ~saddr_par_f(reqAddr); // [R4]
          nxt_st.link.stbOut = '1;
          nxt_st.link.oe = 1'b1;
          nxt_st.link.cnt = HALF_M1;
          nxt_st.link.tx = TX_ADDR;
        end
      end
      TX_ADDR: begin
        // address settled for a half period, assert strobes
        if (tick) begin
          nxt_st.link.stbOut = '0; // [R5]
          nxt_st.link.tx = TX_STB;
        end
      end
      TX_STB: begin
        if (tick) begin
          nxt_st.link.lineOut = ~st_ff.link.txType; // [R3]
          nxt_st.link.parOut = ~saddr_par_f(st_ff.link.txType); // [R4]
          nxt_st.link.tx = TX_TYPE;
        end
      end
      TX_TYPE: begin
        if (tick) begin
          nxt_st.link.stbOut = '1; // [R5]
          nxt_st.link.tx = TX_END;
        end
      end
      TX_END: begin
        // hold the type past the rising strobe, then release
        if (tick) begin
          nxt_st.link.oe = 1'b0;
          nxt_st.link.txDone = 1'b1;
          nxt_st.link.tx = TX_IDLE;
        end
      end
    endcase
    // synchroniser shift, first stage feeds only the second
    nxt_st.link.sync[0] = {bus.parLvl, bus.stbLvl, bus.lineLvl};
    nxt_st.link.sync[1] = st_ff.link.sync[0];
    nxt_st.link.sync[2] = st_ff.link.sync[1];
    // strobe edges, own phases are tracked but not captured
    for (int i = 0; i < STB_W; i++) begin
      if (stbStable[i] && (stbNow[i] != st_ff.link.stbFilt[i])) begin
        nxt_st.link.stbFilt[i] = stbNow[i];
        if (!st_ff.link.oe && !strapOn) begin
          if (!stbNow[i]) begin
            nxt_st.link.rxAddr = (nxt_st.link.rxAddr & ~saddr_grp_f(i)) | (lineAct & saddr_grp_f(i)); // [R2] [R5]
            if (i == 1) begin
              nxt_st.link.rxParA = parAct;
            end
          end else begin
            nxt_st.link.rxType = (nxt_st.link.rxType & ~saddr_grp_f(i)) | (lineAct & saddr_grp_f(i)); // [R3] [R5]
            if (i == 1) begin
              nxt_st.link.rxValid = 1'b1;
              nxt_st.link.rxParErr = (saddr_par_f(nxt_st.link.rxAddr) != st_ff.link.rxParA)
                | (saddr_par_f(nxt_st.link.rxType) != parAct); // [R4]
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, lines idle high out of reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.link.stbOut <= '1;
      st_ff.link.lineOut <= '1;
      st_ff.link.parOut <= '1;
      st_ff.link.sync <= '1;
      st_ff.link.stbFilt <= '1;
      st_ff.strapCnt <= STRAP_HOLD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pins: straps win while held, which also blocks requests
  assign bus.agtLineOe = st_ff.link.oe | strapOn;
  assign bus.agtLineOut = strapOn ? strapLines : st_ff.link.lineOut;
  assign bus.agtParOut = strapOn ? 2'h3 : st_ff.link.parOut;
  assign bus.agtStbOut = strapOn ? 2'h3 : st_ff.link.stbOut;
  assign reqReady = (st_ff.link.tx == TX_IDLE) && !strapOn && (st_ff.link.stbFilt == 2'h3);
  assign txDone = st_ff.link.txDone;
  assign rxValid = st_ff.link.rxValid;
  assign rxAddr = st_ff.link.rxAddr;
  assign rxType = st_ff.link.rxType;
  assign rxParErr = st_ff.link.rxParErr;

endmodule

// ### saddr_checker.sv
// saddr_checker: concurrent checks on the address group wires between both ends
`timescale 1ns/1ps
module saddr_checker
  import saddr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire saddr_bus_t procLineOut,
  input wire logic procLineOe,
  input wire logic [1:0] procParOut,
  input wire logic [1:0] procStbOut,
  input wire saddr_bus_t agtLineOut,
  input wire logic agtLineOe,
  input wire logic [1:0] agtParOut,
  input wire logic [1:0] agtStbOut
);
  // one clock domain, so one default clocking and disable
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // expected parity levels, lines are inverted back to logic values first
  logic [1:0] procParExp; // low level means parity one
  logic [1:0] agtParExp; // same for the agent end
  assign procParExp = ~{^(~procLineOut & PAR_GRP1), ^(~procLineOut & PAR_GRP0)};
  assign agtParExp = ~{^(~agtLineOut & PAR_GRP1), ^(~agtLineOut & PAR_GRP0)};

  ////////////////////////////////////////////////////////////////////////////
  // parity follows the lines; agent only while its strobes are low, as its strap drive carries none
  a_proc_par_valid: assert property (procLineOe |-> procParOut == procParExp)
    else $error("proc parity does not cover its lines");
  a_agt_par_valid: assert property (agtLineOe && agtStbOut == 2'b00 |-> agtParOut == agtParExp)
    else $error("agent parity does not cover its lines");
  // both strobes move together while driven
  a_proc_stb_pair: assert property (procLineOe |-> procStbOut[0] == procStbOut[1])
    else $error("proc strobes split");
  a_agt_stb_pair: assert property (agtLineOe |-> agtStbOut[0] == agtStbOut[1])
    else $error("agent strobes split");
  // strobes idle for one half, then fall
  a_proc_start_seq: assert property ($rose(procLineOe) |-> (procStbOut == 2'b11)[*4] ##1 procStbOut == 2'b00)
    else $error("proc strobe start timing wrong");
  a_agt_start_seq: assert property ($rose(agtLineOe) |-> (agtStbOut == 2'b11)[*4] ##1 agtStbOut == 2'b00)
    else $error("agent strobe start timing wrong");
  // address stays put while strobes are low in sub-phase one
  a_proc_addr_hold: assert property ($fell(procStbOut[0]) |->
    (procLineOe && procStbOut == 2'b00 && $stable(procLineOut))[*4])
    else $error("proc address moved under low strobe");
  // type stays put after the rising strobe, then the group is released
  a_proc_type_hold: assert property ($rose(procStbOut[0]) && procLineOe |->
    ($stable(procLineOut))[*4] ##1 !procLineOe)
    else $error("proc type hold or release wrong");

  // main scenarios reached
  c_proc_send: cover property ($rose(procLineOe));
  c_agt_send: cover property ($rose(agtLineOe));
  c_back_to_back: cover property ($fell(procLineOe) ##[1:4] $rose(procLineOe));
endmodule

// ### saddr_if.sv
// saddr_if: the shared address group wires joining the processor end and the agent end
`timescale 1ns/1ps
interface saddr_if;
  import saddr_pkg::*;
  // processor end drive
  saddr_bus_t procLineOut;
  logic procLineOe;
  logic [1:0] procParOut;
  logic [1:0] procStbOut;
  // agent end drive
  saddr_bus_t agtLineOut;
  logic agtLineOe;
  logic [1:0] agtParOut;
  logic [1:0] agtStbOut;
  // resolved levels, pulled high when nobody drives (deasserted) [R7]
  saddr_bus_t lineLvl;
  logic [1:0] parLvl;
  logic [1:0] stbLvl;

  // wired-and of both drivers, one enable covers lines, parity and strobes
  assign lineLvl = (procLineOe ? procLineOut : '1) & (agtLineOe ? agtLineOut : '1);
  assign parLvl = (procLineOe ? procParOut : '1) & (agtLineOe ? agtParOut : '1);
  assign stbLvl = (procLineOe ? procStbOut : '1) & (agtLineOe ? agtStbOut : '1);

  modport proc_mp (
    output procLineOut, procLineOe, procParOut, procStbOut,
    input lineLvl, parLvl, stbLvl
  );
  modport agt_mp (
    output agtLineOut, agtLineOe, agtParOut, agtStbOut,
    input lineLvl, parLvl, stbLvl
  );
endinterface

// ### saddr_pkg.sv
// saddr_pkg: shared constants, types and helpers for both ends of the address phase link
// Functional notes
// R1: 35 lines, bits 37..3, 2^38 byte space
// R2: sub-phase one carries the physical address
// R3: sub-phase two carries transaction type instead
// R4: two parity lines cover address lines, checked
// R5: receivers capture lines on sender-driven strobes
// R6: device samples config lines at reset release
// R7: address, parity and strobes are active low
package saddr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths of the address group
  localparam int ADDR_W = 35; // lines 37 down to 3 [R1]
  localparam int ADDR_MSB = 37; // top line number
  localparam int ADDR_LSB = 3; // bottom line number, byte offset below it
  localparam int SPACE_BITS = 38; // reach of the physical space in bits [R1]
  localparam int PAR_W = 2; // parity pair
  localparam int STB_W = 2; // strobe pair
  localparam int SYNC_W = ADDR_W + STB_W + PAR_W; // lines, strobes, parity
  localparam int SYNC_DEPTH = 3; // pin synchroniser depth

  // bit groups: strobe 0 owns lines 16..3, strobe 1 owns lines 37..17
  localparam logic [34:0] STB_GRP0 = 35'h0_0000_3FFF;
  localparam logic [34:0] STB_GRP1 = 35'h7_FFFF_C000;
  // parity 0 covers lines 37..24, parity 1 covers lines 23..3
  localparam logic [34:0] PAR_GRP0 = 35'h7_FFE0_0000;
  localparam logic [34:0] PAR_GRP1 = 35'h0_001F_FFFF;

  ////////////////////////////////////////////////////////////////////////////
  // timing: each sub-phase half lasts one half strobe period
  localparam int REF_CLK_MHZ = 10; // ref_clk rate
  localparam int STB_HALF_NS = 400; // half of an 800 ns strobe period
  localparam logic [7:0] HALF_CYC = 8'((STB_HALF_NS * REF_CLK_MHZ) / 1000);
  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 8'h01);

  // power-on configuration straps on the low address lines
  localparam int CFG_LO = 0; // index of line 3
  localparam int CFG_W = 8; // lines 10..3
  localparam logic [3:0] CFG_WAIT = 4'(SYNC_DEPTH + 1); // device waits this long
  localparam logic [3:0] STRAP_HOLD = 4'(SYNC_DEPTH + 3); // far end holds longer

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [ADDR_W-1:0] saddr_bus_t;
  typedef enum logic [2:0] {TX_IDLE, TX_ADDR, TX_STB, TX_TYPE, TX_END} saddr_tx_t;

  // state shared by both ends: sender, synchroniser and receiver
  typedef struct packed {
    saddr_tx_t tx; // sender phase
    logic [7:0] cnt; // half period divider
    saddr_bus_t txType; // type held for sub-phase two
    saddr_bus_t lineOut; // electrical line levels driven
    logic [1:0] parOut; // electrical parity levels
    logic [1:0] stbOut; // electrical strobe levels
    logic oe; // drive enable for the whole group
    logic txDone; // transfer finished pulse
    logic [2:0][SYNC_W-1:0] sync; // pin synchroniser stages
    logic [1:0] stbFilt; // agreed strobe levels
    saddr_bus_t rxAddr; // captured address
    saddr_bus_t rxType; // captured type
    logic [1:0] rxParA; // parity seen with the address
    logic rxValid; // capture complete pulse
    logic rxParErr; // parity mismatch on the capture
  } saddr_link_t;

  // active-high parity bits that make each covered group even [R4]
  function automatic logic [1:0] saddr_par_f(input saddr_bus_t b);
    saddr_par_f = {^(b & PAR_GRP1), ^(b & PAR_GRP0)};
  endfunction

  // bits owned by a strobe
  function automatic saddr_bus_t saddr_grp_f(input int i);
    saddr_grp_f = (i == 0) ? STB_GRP0 : STB_GRP1;
  endfunction

endpackage

// ### saddr_proc_end.sv
// saddr_proc_end: processor end of the address phase, with power-on config capture
`timescale 1ns/1ps
module saddr_proc_end
  import saddr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  saddr_if.proc_mp bus,
  input wire logic reqValid,
  output logic reqReady,
  input wire saddr_bus_t reqAddr,
  input wire saddr_bus_t reqType,
  output logic txDone,
  output logic rxValid,
  output saddr_bus_t rxAddr,
  output saddr_bus_t rxType,
  output logic rxParErr,
  output logic cfgValid,
  output logic [CFG_W-1:0] cfgBits
);

  ////////////////////////////////////////////////////////////////////////////
  // state declarations

  // whole state of this end
  typedef struct packed {
    saddr_link_t link; // common sender and receiver
    logic [3:0] cfgCnt; // wait before strap capture
    logic cfgValid; // configuration captured
    logic [CFG_W-1:0] cfg; // captured configuration
  } saddr_proc_st_t;

  saddr_proc_st_t st_ff; // registered state
  saddr_proc_st_t nxt_st; // next state
  logic tick; // divider pulse, end of a half period
  logic [1:0] stbNow; // synchronised strobe levels
  logic [1:0] stbStable; // second and third stage agree
  saddr_bus_t lineAct; // synchronised lines, active high
  logic [1:0] parAct; // synchronised parity, active high
  logic busQuiet; // both strobes deasserted

  // divider end: the counter reloads to a half period on each pulse
  assign tick = (st_ff.link.cnt == 8'h00);

  // decoded views of the last two synchroniser stages
  assign stbNow = st_ff.link.sync[2][ADDR_W +: STB_W];
  assign stbStable = ~(st_ff.link.sync[1][ADDR_W +: STB_W] ^ stbNow);
  assign lineAct = ~st_ff.link.sync[2][ADDR_W-1:0]; // [R7]
  assign parAct = ~st_ff.link.sync[2][ADDR_W+STB_W +: PAR_W]; // [R7]

  // arbitration is outside this block; only a quiet bus is claimed
  assign busQuiet = (st_ff.link.stbFilt == 2'h3);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;
    // pulses last one cycle
    nxt_st.link.txDone = 1'b0;
    nxt_st.link.rxValid = 1'b0;

    // config capture once the reset value has left the synchroniser
    if (st_ff.cfgCnt != 4'h0) begin
      nxt_st.cfgCnt = 4'(st_ff.cfgCnt - 4'h1);
      // last count: sync stage three now holds the strap levels
      if (st_ff.cfgCnt == 4'h1) begin
        nxt_st.cfgValid = 1'b1; // [R6]
        nxt_st.cfg = lineAct[CFG_LO +: CFG_W]; // [R6]
      end
    end

    // divider runs only while a phase is on the wires
    if (st_ff.link.tx != TX_IDLE) begin
      nxt_st.link.cnt = tick ? HALF_M1 : 8'(st_ff.link.cnt - 8'h01);
    end

    // sender: four half periods per transfer
    unique case (st_ff.link.tx)
      TX_IDLE: begin
        // take a request only once configured and on a quiet bus
        if (reqValid && reqReady) begin
          nxt_st.link.txType = reqType;
          nxt_st.link.lineOut = ~reqAddr; // [R2] [R7]
          nxt_st.link.parOut = ~saddr_par_f(reqAddr); // [R4]
          nxt_st.link.stbOut = '1;
          nxt_st.link.oe = 1'b1;
          nxt_st.link.cnt = HALF_M1;
          nxt_st.link.tx = TX_ADDR;
        end
      end
      TX_ADDR: begin
        // address set up for a half period, then strobes fall
        if (tick) begin
          nxt_st.link.stbOut = '0; // [R5]
          nxt_st.link.tx = TX_STB;
        end
      end
      TX_STB: begin
        // address held past the falling strobe, then type replaces it
        if (tick) begin
          nxt_st.link.lineOut = ~st_ff.link.txType; // [R3]
          nxt_st.link.parOut = ~saddr_par_f(st_ff.link.txType); // [R4]
          nxt_st.link.tx = TX_TYPE;
        end
      end
      TX_TYPE: begin
        // type set up for a half period, then strobes rise
        if (tick) begin
          nxt_st.link.stbOut = '1; // [R5]
          nxt_st.link.tx = TX_END;
        end
      end
      TX_END: begin
        // type held past the rising strobe, then the group is released
        if (tick) begin
          nxt_st.link.oe = 1'b0;
          nxt_st.link.txDone = 1'b1;
          nxt_st.link.tx = TX_IDLE;
        end
      end
    endcase

    // synchroniser shift, first stage feeds only the second
    nxt_st.link.sync[0] = {bus.parLvl, bus.stbLvl, bus.lineLvl};
    nxt_st.link.sync[1] = st_ff.link.sync[0];
    nxt_st.link.sync[2] = st_ff.link.sync[1];

    // receiver: an edge counts when stages two and three agree on a new level;
    // own phases are tracked so the filter ends idle, but never captured
    for (int i = 0; i < STB_W; i++) begin
      if (stbStable[i] && (stbNow[i] != st_ff.link.stbFilt[i])) begin
        nxt_st.link.stbFilt[i] = stbNow[i];
        if (!st_ff.link.oe) begin
          if (!stbNow[i]) begin
            // falling strobe closes sub-phase one for its bits
            nxt_st.link.rxAddr = (nxt_st.link.rxAddr & ~saddr_grp_f(i)) | (lineAct & saddr_grp_f(i)); // [R2] [R5]
            if (i == 1) begin
              nxt_st.link.rxParA = parAct;
            end
          end else begin
            // rising strobe closes sub-phase two for its bits
            nxt_st.link.rxType = (nxt_st.link.rxType & ~saddr_grp_f(i)) | (lineAct & saddr_grp_f(i)); // [R3] [R5]
            if (i == 1) begin
              // strobe 1 is handled after strobe 0, so both halves are in
              nxt_st.link.rxValid = 1'b1;
              nxt_st.link.rxParErr = (saddr_par_f(nxt_st.link.rxAddr) != st_ff.link.rxParA)
                | (saddr_par_f(nxt_st.link.rxType) != parAct); // [R4]
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, lines idle high (deasserted) out of reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.link.stbOut <= '1;
      st_ff.link.lineOut <= '1;
      st_ff.link.parOut <= '1;
      st_ff.link.sync <= '1;
      st_ff.link.stbFilt <= '1;
      st_ff.cfgCnt <= CFG_WAIT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // pins: one enable for the whole group, undriven lines float high
  assign bus.procLineOe = st_ff.link.oe;
  assign bus.procLineOut = st_ff.link.lineOut;
  assign bus.procParOut = st_ff.link.parOut;
  assign bus.procStbOut = st_ff.link.stbOut;

  // user side
  assign reqReady = (st_ff.link.tx == TX_IDLE) && st_ff.cfgValid && busQuiet;
  assign txDone = st_ff.link.txDone;
  assign rxValid = st_ff.link.rxValid;
  assign rxAddr = st_ff.link.rxAddr;
  assign rxType = st_ff.link.rxType;
  assign rxParErr = st_ff.link.rxParErr;
  assign cfgValid = st_ff.cfgValid;
  assign cfgBits = st_ff.cfg;

endmodule

// ### test_system_bus_address_phase.sv
// test_system_bus_address_phase: both ends joined, traffic in both directions and strap capture
`timescale 1ns/1ps
module test_system_bus_address_phase
  import saddr_pkg::*;
;
  logic ref_clk; // 10 MHz reference
  logic rst; // shared reset so the proc end sees the straps
  logic pReqValid, aReqValid; // send requests
  saddr_bus_t pReqAddr, pReqType, aReqAddr, aReqType; // request words
  logic pReqReady, aReqReady, pTxDone, aTxDone; // sender status
  logic pRxValid, aRxValid, pRxParErr, aRxParErr; // receiver status
  saddr_bus_t pRxAddr, pRxType, aRxAddr, aRxType; // captured words
  logic cfgValid; // strap capture done
  logic [CFG_W-1:0] cfgBits, strapBits; // captured and applied straps
  int errTotal = 0;
  int checksDone = 0;
  int cycleCnt = 0;

  saddr_if busIf ();
  saddr_proc_end u_saddr_proc_end (.ref_clk(ref_clk), .rst(rst), .bus(busIf.proc_mp), .reqValid(pReqValid),
    .reqReady(pReqReady), .reqAddr(pReqAddr), .reqType(pReqType), .txDone(pTxDone), .rxValid(pRxValid),
    .rxAddr(pRxAddr), .rxType(pRxType), .rxParErr(pRxParErr), .cfgValid(cfgValid), .cfgBits(cfgBits));
  saddr_agent_end u_saddr_agent_end (.ref_clk(ref_clk), .rst(rst), .bus(busIf.agt_mp), .reqValid(aReqValid),
    .reqReady(aReqReady), .reqAddr(aReqAddr), .reqType(aReqType), .txDone(aTxDone), .rxValid(aRxValid),
    .rxAddr(aRxAddr), .rxType(aRxType), .rxParErr(aRxParErr), .strapBits(strapBits));
  saddr_checker u_saddr_checker (.ref_clk(ref_clk), .rst(rst), .procLineOut(busIf.procLineOut),
    .procLineOe(busIf.procLineOe), .procParOut(busIf.procParOut), .procStbOut(busIf.procStbOut),
    .agtLineOut(busIf.agtLineOut), .agtLineOe(busIf.agtLineOe), .agtParOut(busIf.agtParOut),
    .agtStbOut(busIf.agtStbOut));

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // even parity per group, worked out independently of the design
  function automatic logic [1:0] exp_par(input saddr_bus_t b);
    exp_par = {^(b & PAR_GRP1), ^(b & PAR_GRP0)};
  endfunction

  // compare and count
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one address phase, dir 0 proc sends, dir 1 agent sends; wire and receiver both judged
  task automatic send_one(input logic dir, input saddr_bus_t addr, input saddr_bus_t typ);
    logic [1:0] prevStb;
    logic gotRx, gotDone;
    int n;
    prevStb = 2'b11;
    gotRx = 1'b0;
    gotDone = 1'b0;
    n = 0;
    @(posedge ref_clk);
    if (dir) begin
      aReqValid <= 1'b1;
      aReqAddr <= addr;
      aReqType <= typ;
    end else begin
      pReqValid <= 1'b1;
      pReqAddr <= addr;
      pReqType <= typ;
    end
    // ready is read mid-cycle, so the request is taken at the next edge
    do begin
      @(negedge ref_clk);
      n++;
    end while ((dir ? aReqReady : pReqReady) !== 1'b1 && n < 50);
    @(posedge ref_clk);
    pReqValid <= 1'b0;
    aReqValid <= 1'b0;
    for (n = 0; n < 60 && !(gotRx && gotDone); n++) begin
      @(negedge ref_clk);
      if (prevStb == 2'b11 && busIf.stbLvl == 2'b00) begin
        chk(busIf.lineLvl, ~addr);
        // concatenation keeps the inversion at two bits; a size cast would invert the padding too
        chk({33'h0_0000_0000, busIf.parLvl}, {33'h0_0000_0000, ~exp_par(addr)});
      end
      if (prevStb == 2'b00 && busIf.stbLvl == 2'b11) begin
        chk(busIf.lineLvl, ~typ);
        chk({33'h0_0000_0000, busIf.parLvl}, {33'h0_0000_0000, ~exp_par(typ)});
      end
      prevStb = busIf.stbLvl;
      if ((dir ? aTxDone : pTxDone) === 1'b1) gotDone = 1'b1;
      if ((dir ? pRxValid : aRxValid) === 1'b1) begin
        gotRx = 1'b1;
        chk(dir ? pRxAddr : aRxAddr, addr);
        chk(dir ? pRxType : aRxType, typ);
        chk(35'(dir ? pRxParErr : aRxParErr), 35'h0_0000_0000);
      end
    end
    chk({33'h0_0000_0000, gotRx, gotDone}, 35'h0_0000_0003);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_config;
    int n;
    n = 0;
    while (cfgValid !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk(35'(cfgValid), 35'h0_0000_0001);
    chk(35'(cfgBits), 35'(strapBits));
  endtask

  // extremes of the 35-line space, each with a type one off the opposite extreme
  task automatic t_proc_to_agent;
    send_one(1'b0, 35'h7_FFFF_FFFF, 35'h0_0000_0001);
    send_one(1'b0, 35'h0_0000_0000, 35'h7_FFFF_FFFE);
  endtask

  task automatic t_agent_to_proc;
    send_one(1'b1, 35'h5_5555_5555, 35'h2_AAAA_AAAA);
  endtask

  // two idle cycles between phases, then a turn of direction straight away
  task automatic t_back_to_back;
    send_one(1'b0, 35'h1_2345_6789, 35'h0_0ABC_DEF0);
    send_one(1'b0, 35'h6_0000_4001, 35'h3_FFFF_C000);
    send_one(1'b1, 35'h0_0020_0000, 35'h4_0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    pReqValid = 1'b0;
    aReqValid = 1'b0;
    pReqAddr = '0;
    pReqType = '0;
    aReqAddr = '0;
    aReqType = '0;
    strapBits = 8'hA5;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_config;
    t_proc_to_agent;
    t_agent_to_proc;
    t_back_to_back;
    complete_run;
  end

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 5000) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, cycleCnt, 0);
      complete_run;
    end
  end
endmodule
